//--- sim/reset_stretch_sequencer_tb_top.sv
// self-checking testbench of the reset stretch sequencer
`timescale 1ns/1ps
`default_nettype none

module reset_stretch_sequencer_tb_top;
   // ==========================================
   // shortened counts
   localparam int POR_T = 20;
   localparam int SDRAM_T = 7;
   localparam int SYS_T = 14;
   localparam int QUAL_T = 4;

   logic clock;
   logic srst;
   logic slow_ref_clk;
   logic por_in_n;
   logic hard_req_n;
   logic int_por_rst;
   logic sdram_rst;
   logic core_sys_rst;
   logic rst_out_pin_n;
   logic prev_slow; // slow clock at last sampled edge
   int err_total;
   int tests_run;

   reset_stretch_sequencer #(
      .POR_TICKS(POR_T),
      .SDRAM_TICKS(SDRAM_T),
      .SYS_TICKS(SYS_T),
      .QUAL_TICKS(QUAL_T)
   ) u_dut (
      .clock(clock),
      .srst(srst),
      .slow_ref_clk(slow_ref_clk),
      .por_in_n(por_in_n),
      .hard_req_n(hard_req_n),
      .int_por_rst(int_por_rst),
      .sdram_rst(sdram_rst),
      .core_sys_rst(core_sys_rst),
      .rst_out_pin_n(rst_out_pin_n)
   );

   reset_supervisor_model u_sup (
      .clock(clock),
      .slow_ref_clk(slow_ref_clk),
      .por_in_n(por_in_n),
      .hard_req_n(hard_req_n)
   );

   // 250 MHz clock
   initial begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end

   // ==========================================
   // reporting
   task automatic wrap_up();
      if (err_total == 0 && tests_run > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : wrap_up

   task automatic check_bit(input string name, input logic expv, input logic got);
      tests_run++;
      if (got !== expv) begin
         err_total++;
         $display("unexpected %s: expected %b seen %b", name, expv, got);
      end
   endtask : check_bit

   task automatic check_count(input string name, input int expv, input int got);
      tests_run++;
      if (got != expv) begin
         err_total++;
         $display("unexpected %s: expected %0d seen %0d", name, expv, got);
      end
   endtask : check_count

   // selected reset output
   function automatic logic watch(input int sel);
      case (sel)
         0: return int_por_rst;
         1: return sdram_rst;
         default: return core_sys_rst;
      endcase
   endfunction : watch

   // count slow ticks until the watched reset reaches level
   task automatic measure(input int sel, input logic level, input int expv, input string name);
      int ticks;
      int n;
      ticks = 0;
      for (n = 0; n < 4000; n++) begin
         @(posedge clock);
         #1;
         if (slow_ref_clk && !prev_slow) ticks++;
         prev_slow = slow_ref_clk;
         if (watch(sel) === level) break;
      end
      if (n == 4000) begin
         check_count(name, expv, -1);
         wrap_up();
      end
      check_count(name, expv, ticks);
   endtask : measure

   // pin follows the system reset one clock late
   task automatic pin_lag(input logic final_level);
      check_bit("rst_out_pin_n", ~final_level, rst_out_pin_n);
      @(posedge clock);
      #1;
      check_bit("rst_out_pin_n", final_level, rst_out_pin_n);
      prev_slow = slow_ref_clk;
   endtask : pin_lag

   // ==========================================
   // scenarios
   task automatic t_reset_values();
      check_bit("int_por_rst", 1'b1, int_por_rst);
      check_bit("sdram_rst", 1'b1, sdram_rst);
      check_bit("core_sys_rst", 1'b1, core_sys_rst);
      check_bit("rst_out_pin_n", 1'b0, rst_out_pin_n);
   endtask : t_reset_values

   // power-on width, then both stretches from its release
   task automatic t_power_on();
      u_sup.set_por(1'b0);
      repeat (2) @(posedge clock);
      #1;
      check_bit("int_por_rst", 1'b1, int_por_rst);
      check_bit("sdram_rst", 1'b1, sdram_rst);
      u_sup.set_por(1'b1);
      prev_slow = slow_ref_clk;
      measure(0, 1'b0, POR_T, "power-on ticks");
      check_bit("core_sys_rst", 1'b1, core_sys_rst);
      measure(1, 1'b0, SDRAM_T, "sdram ticks");
      measure(2, 1'b0, SYS_T - SDRAM_T, "system ticks");
      pin_lag(1'b1);
   endtask : t_power_on

   // three slow cycles of request are too short
   task automatic t_short_request();
      logic seen;
      seen = 1'b0;
      u_sup.pulse_request(3);
      repeat (80) begin
         @(posedge clock);
         #1;
         seen = seen | sdram_rst;
      end
      check_bit("sdram_rst short request", 1'b0, seen);
   endtask : t_short_request

   // qualified request restarts both stretches together
   task automatic t_hard_request();
      u_sup.pulse_request(4);
      prev_slow = slow_ref_clk;
      measure(1, 1'b1, QUAL_T, "qualifier ticks");
      check_bit("core_sys_rst", 1'b1, core_sys_rst);
      pin_lag(1'b0);
      measure(1, 1'b0, SDRAM_T, "sdram ticks");
      measure(2, 1'b0, SYS_T - SDRAM_T, "system ticks");
      pin_lag(1'b1);
   endtask : t_hard_request

   // main sequence
   initial begin
      err_total = 0;
      tests_run = 0;
      srst = 1'b1;
      prev_slow = 1'b0;
      repeat (20) @(negedge clock);
      t_reset_values();
      srst = 1'b0;
      t_power_on();
      t_short_request();
      t_hard_request();
      t_power_on();
      wrap_up();
   end
endmodule : reset_stretch_sequencer_tb_top
`default_nettype wire

//--- sim/reset_supervisor_model.sv
// board supervisor model: slow reference clock, power-on input, hard request
`timescale 1ns/1ps
`default_nettype none

module reset_supervisor_model #(
   parameter int HALF = 4 // clocks per slow half period
) (
   input wire logic clock,
   output logic slow_ref_clk,
   output logic por_in_n,
   output logic hard_req_n
);
   // ==========================================
   // free-running slow reference
   int div_q = 0; // half-period divider

   // power-on held, no request
   initial begin
      slow_ref_clk = 1'b0;
      por_in_n = 1'b0;
      hard_req_n = 1'b1;
   end

   // toggle off the sampling edge
   always @(negedge clock) begin
      div_q <= (div_q == HALF - 1) ? 0 : div_q + 1;
      if (div_q == HALF - 1) begin
         slow_ref_clk <= ~slow_ref_clk;
      end
   end

   // ==========================================
   // stimulus tasks
   // poll falling edges until a slow rise is seen, bounded by two slow periods
   task automatic align();
      logic was;
      was = slow_ref_clk;
      for (int i = 0; i < 4 * HALF; i++) begin
         @(negedge clock);
         if (slow_ref_clk && !was) break;
         was = slow_ref_clk;
      end
   endtask : align

   // drive the power-on input
   task automatic set_por(input logic level);
      align();
      por_in_n = level;
   endtask : set_por

   // hold the request low across n slow rises
   task automatic pulse_request(input int n);
      align();
      hard_req_n = 1'b0;
      repeat (n) align();
      hard_req_n = 1'b1;
   endtask : pulse_request
endmodule : reset_supervisor_model
`default_nettype wire

//--- src/reset_stretch_defs.svh
// timing constants of the reset stretch sequencer
`ifndef RESET_STRETCH_DEFS_SVH
`define RESET_STRETCH_DEFS_SVH

// ==========================================================
// slow reference clock
`define RSS_SLOW_HZ 32000
`define RSS_K 1024

// ==========================================================
// internal power-on reset width, in ms and in slow ticks
`define RSS_POR_MS 300
`define RSS_POR_TICKS ((`RSS_POR_MS * `RSS_SLOW_HZ) / 1000)

// ==========================================================
// stretcher and qualifier lengths, in slow ticks
`define RSS_SDRAM_TICKS (7 * `RSS_K)
`define RSS_SYS_TICKS (14 * `RSS_K)
`define RSS_QUAL_TICKS (4 * `RSS_K)
`define RSS_REQ_MIN_TICKS 4

// ==========================================================
// counter width shared by the power-on, qualifier and stretch slow-tick counters
`define RSS_CNT_W 16

`endif

//--- src/reset_stretch_pkg.sv
// types of the reset stretch sequencer
`default_nettype none
package reset_stretch_pkg;

   // ==========================================================
   // power-on reset phases
   typedef enum logic [1:0] {
      POR_HOLD  = 2'b00, // power-on input still asserted
      POR_COUNT = 2'b01, // timing the internal power-on width
      POR_DONE  = 2'b10  // power-on reset released
   } por_state_e;

   // ==========================================================
   // hard reset request tracking
   typedef struct packed {
      logic pending;   // request recognised, qualifier running
      logic [2:0] seen; // consecutive slow ticks with request held
   } req_track_s;

endpackage : reset_stretch_pkg
`default_nettype wire

//--- src/reset_stretch_sequencer.sv
// reset sequencer: power-on width, request qualifier, stretched resets
// What this block does
// - hold internal power-on reset for 300 ms
// - stretch SDRAM reset to 7K slow cycles
// - stretch system reset 14K, mirror on pin
// - qualifier counts 4K slow cycles before acting
`timescale 1ns/1ps
`default_nettype none
`include "reset_stretch_defs.svh"

module reset_stretch_sequencer #(
   parameter int unsigned POR_TICKS = `RSS_POR_TICKS,
   parameter int unsigned SDRAM_TICKS = `RSS_SDRAM_TICKS,
   parameter int unsigned SYS_TICKS = `RSS_SYS_TICKS,
   parameter int unsigned QUAL_TICKS = `RSS_QUAL_TICKS
) (
   input wire logic clock,
   input wire logic srst,
   input wire logic slow_ref_clk,
   input wire logic por_in_n,
   input wire logic hard_req_n,
   output logic int_por_rst,
   output logic sdram_rst,
   output logic core_sys_rst,
   output logic rst_out_pin_n
);

   localparam int CW = `RSS_CNT_W;
   localparam logic [2:0] REQ_LAST = 3'(`RSS_REQ_MIN_TICKS - 1);

   // ==========================================================
   // slow clock edge detection
   logic slow_q; // slow clock one system cycle ago
   logic tick_w; // rising edge of the slow reference
   assign tick_w = slow_ref_clk & ~slow_q;

   always_ff @(posedge clock) begin
      if (srst) begin
         // starts high so a slow clock already high at release is no false tick
         slow_q <= 1'b1;
      end else begin
         slow_q <= slow_ref_clk;
      end
   end

   // ==========================================================
   // internal power-on reset
   reset_stretch_pkg::por_state_e por_q; // power-on phase
   reset_stretch_pkg::por_state_e por_d;
   logic [CW-1:0] por_cnt_q; // slow ticks timed in the counting phase
   logic [CW-1:0] por_cnt_d;
   logic por_last_w; // last tick of the power-on width
   logic por_release_w; // one-cycle pulse as power-on reset ends
   logic int_por_d;

   assign por_last_w = (por_cnt_q == CW'(POR_TICKS - 1));
   assign por_release_w = (por_q == reset_stretch_pkg::POR_COUNT) && tick_w && por_last_w;
   assign int_por_d = (por_d != reset_stretch_pkg::POR_DONE);

   // phase walk; a fresh power-on input always goes back to hold
   always_comb begin
      por_d = por_q;
      por_cnt_d = por_cnt_q;
      case (por_q)
         reset_stretch_pkg::POR_HOLD: begin
            por_cnt_d = '0;
            // input released: begin timing the width
            if (por_in_n) begin
               por_d = reset_stretch_pkg::POR_COUNT;
            end
         end
         reset_stretch_pkg::POR_COUNT: begin
            // count slow ticks up to the full width
            if (por_release_w) begin
               por_d = reset_stretch_pkg::POR_DONE;
            end else if (tick_w) begin
               por_cnt_d = por_cnt_q + 1'b1;
            end
         end
         reset_stretch_pkg::POR_DONE: begin
            por_cnt_d = '0;
         end
         default: begin
            por_d = reset_stretch_pkg::POR_HOLD;
            por_cnt_d = '0;
         end
      endcase
      // power-on input overrides every phase
      if (!por_in_n) begin
         por_d = reset_stretch_pkg::POR_HOLD;
         por_cnt_d = '0;
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         por_q <= reset_stretch_pkg::POR_HOLD;
         por_cnt_q <= '0;
         int_por_rst <= 1'b1;
      end else begin
         por_q <= por_d;
         por_cnt_q <= por_cnt_d;
         int_por_rst <= int_por_d;
      end
   end

   // ==========================================================
   // hard reset request recognition and qualifier
   reset_stretch_pkg::req_track_s req_q; // recognition state
   reset_stretch_pkg::req_track_s req_d;
   logic [CW-1:0] qual_cnt_q; // slow ticks spent qualifying
   logic [CW-1:0] qual_cnt_d;
   logic qual_last_w; // final qualifier tick
   logic fire_w; // qualified request takes effect now
   logic recog_w; // request held long enough to be recognised

   assign qual_last_w = (qual_cnt_q == CW'(QUAL_TICKS - 1));
   assign fire_w = req_q.pending && tick_w && qual_last_w;
   // short glitches never reach the seen count of three held on a fourth tick
   assign recog_w = !hard_req_n && tick_w && (req_q.seen == REQ_LAST);

   always_comb begin
      req_d = req_q;
      qual_cnt_d = qual_cnt_q;
      if (req_q.pending) begin
         // qualifying; further requests are absorbed
         req_d.seen = '0;
         if (fire_w) begin
            req_d.pending = 1'b0;
            qual_cnt_d = '0;
         end else if (tick_w) begin
            qual_cnt_d = qual_cnt_q + 1'b1;
         end
      end else if (hard_req_n || int_por_rst) begin
         // request gone, or power-on already resets all
         req_d.seen = '0;
         qual_cnt_d = '0;
      end else if (recog_w) begin
         req_d.pending = 1'b1;
         req_d.seen = '0;
         qual_cnt_d = '0;
      end else if (tick_w) begin
         req_d.seen = req_q.seen + 3'h1;
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         req_q <= '0;
         qual_cnt_q <= '0;
      end else begin
         req_q <= req_d;
         qual_cnt_q <= qual_cnt_d;
      end
   end

   // ==========================================================
   // stretch channels, both restarted by one event
   logic restart_w; // shared start of both stretches
   assign restart_w = int_por_rst | fire_w;

   reset_stretcher #(
      .LEN(SDRAM_TICKS)
   ) u_sdram_stretch (
      .clock(clock),
      .srst(srst),
      .tick(tick_w),
      .hold(restart_w),
      .rst_q(sdram_rst)
   );

   reset_stretcher #(
      .LEN(SYS_TICKS)
   ) u_sys_stretch (
      .clock(clock),
      .srst(srst),
      .tick(tick_w),
      .hold(restart_w),
      .rst_q(core_sys_rst)
   );

   // reset output pin follows the system reset one cycle later
   always_ff @(posedge clock) begin
      if (srst) begin
         rst_out_pin_n <= 1'b0;
      end else begin
         rst_out_pin_n <= ~core_sys_rst;
      end
   end

   // ==========================================================
   // checks
   default clocking cb @(posedge clock); endclocking
   default disable iff (srst);

   a_por_width: assert property (
      $fell(int_por_rst) |-> $past(por_cnt_q) == CW'(POR_TICKS - 1) && $past(tick_w))
      else $error("power-on reset released at wrong width");

   a_por_input_hold: assert property (
      !por_in_n |=> int_por_rst)
      else $error("power-on reset not held by input");

   a_qual_span: assert property (
      req_q.pending && tick_w && qual_cnt_q == CW'(QUAL_TICKS - 1) |=> !req_q.pending && sdram_rst)
      else $error("qualifier did not fire on its last tick");

   a_qual_bound: assert property (
      req_q.pending |-> qual_cnt_q <= CW'(QUAL_TICKS - 1))
      else $error("qualifier counted past its length");

   a_both_start: assert property (
      fire_w |=> sdram_rst && core_sys_rst)
      else $error("stretches not started together");

   a_sdram_first: assert property (
      $fell(core_sys_rst) |-> !sdram_rst)
      else $error("system reset released before sdram reset");

   a_pin_mirror: assert property (
      ##1 rst_out_pin_n == !$past(core_sys_rst))
      else $error("reset pin does not mirror system reset");

   a_por_covers: assert property (
      int_por_rst |=> sdram_rst)
      else $error("sdram reset free during power-on");

endmodule : reset_stretch_sequencer
`default_nettype wire

//--- src/reset_stretcher.sv
// one reset stretch channel counting slow reference ticks
`timescale 1ns/1ps
`default_nettype none
`include "reset_stretch_defs.svh"

module reset_stretcher #(
   parameter int unsigned LEN = `RSS_SDRAM_TICKS
) (
   input wire logic clock,
   input wire logic srst,
   input wire logic tick,
   input wire logic hold,
   output logic rst_q
);

   localparam int CW = `RSS_CNT_W;

   logic [CW-1:0] cnt_q; // ticks counted since hold dropped
   logic last_w; // final tick of the stretch
   logic [CW-1:0] cnt_d;
   logic rst_d;

   // ==========================================================
   // next state
   assign last_w = (cnt_q == CW'(LEN - 1));
   // hold restarts the stretch; each tick advances it until release
   assign cnt_d = hold ? '0 : ((rst_q && tick && !last_w) ? cnt_q + 1'b1 : cnt_q);
   assign rst_d = hold | (rst_q & ~(tick & last_w));

   // ==========================================================
   // registers
   always_ff @(posedge clock) begin
      if (srst) begin
         cnt_q <= '0;
         rst_q <= 1'b1;
      end else begin
         cnt_q <= cnt_d;
         rst_q <= rst_d;
      end
   end

   // ==========================================================
   // checks
   default clocking cb @(posedge clock); endclocking
   default disable iff (srst);

   a_stretch_length: assert property (
      $fell(rst_q) |-> ($past(cnt_q) == CW'(LEN - 1)) && $past(tick) && !$past(hold))
      else $error("stretch released at wrong count");

endmodule : reset_stretcher
`default_nettype wire
